// >>> hw/ptirq_pkg.sv
// constants of the pressure threshold interrupt block
// assumes byte-wide register access and 24-bit pressure words
package ptirq_pkg;

  // register offsets
  localparam logic [7:0] IRQ_CFG_ADDR = 8'h0b;
  localparam logic [7:0] THS_LOW_ADDR = 8'h0c;
  localparam logic [7:0] THS_HIGH_ADDR = 8'h0d;

  // field positions in pressure_irq_config
  localparam int CFG_HIGH_EN_BIT = 0;
  localparam int CFG_LOW_EN_BIT = 1;
  localparam int CFG_LATCH_BIT = 2;
  localparam int CFG_DIFFERENTIAL_IRQ_ENABLE_BIT = 3;
  localparam int CFG_RESET_OUT_BIT = 4;
  localparam int CFG_OUT_MODE_BIT = 5;
  localparam int CFG_RESET_IRQ_BIT = 6;
  localparam int CFG_IRQ_MODE_BIT = 7;

  // reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] THS_BYTE_RESET = 8'h00;
  localparam logic [23:0] REF_RESET = 24'h000000;

  // top threshold bit is unused
  localparam logic [7:0] THS_HIGH_MASK = 8'h7f;

  // pressure counts per threshold count, as a shift
  localparam int PRESS_TO_THS_SHIFT = 8;

endpackage : ptirq_pkg

// >>> hw/ptirq_compare.sv
// differential value and threshold comparison for one conversion
// assumes the caller registers the results on its own conversion strobe
`timescale 1ns/1ns
module ptirq_compare #(
  parameter int PW = 24,
  parameter int SHIFT = ptirq_pkg::PRESS_TO_THS_SHIFT
) (
  input wire logic [PW-1:0] measured_i,
  input wire logic [PW-1:0] reference_i,
  input wire logic [14:0] threshold_i,
  output logic [PW-1:0] differential_o,
  output logic above_o,
  output logic below_o
);

  logic signed [PW:0] diff_wide;
  logic signed [PW:0] ths_scaled;
  logic signed [PW:0] ths_neg;

  // measured minus reference, kept signed one bit wider
  assign diff_wide = $signed({1'b0, measured_i}) - $signed({1'b0, reference_i});
  assign differential_o = diff_wide[PW-1:0];

  // threshold brought to pressure counts
  assign ths_scaled = $signed((PW+1)'({threshold_i, {SHIFT{1'b0}}}));
  assign ths_neg = -ths_scaled;

  // both directions compared at once
  assign above_o = diff_wide > ths_scaled;
  assign below_o = diff_wide < ths_neg;

endmodule : ptirq_compare

// >>> hw/ptirq_top.sv
// pressure threshold interrupt: config and threshold registers,
// self-reference capture and per-conversion threshold compare
// assumes one clock, a one-cycle conversion strobe with the measured
// pressure beside it, and a byte register port with one-cycle strobes
//
// Overview of operation
// - low enable: request when differential below threshold
// - high enable: request when differential above threshold
// - high enable bit resets to zero
// - active only with diff enable and an event enable
// - compare differential against threshold, both directions
// - threshold is 15 bits from two bytes
// - irq reference mode: capture reference, output unchanged
// - irq reference mode bit clears after one conversion
// - output zeroing mode: capture reference, output difference
`timescale 1ns/1ns
module ptirq_top #(
  parameter int PW = 24
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic conv_done_i,
  input wire logic [PW-1:0] measured_i,
  output logic [PW-1:0] press_out_o,
  output logic [PW-1:0] differential_pressure_o,
  output logic press_valid_o,
  output logic irq_high_o,
  output logic irq_low_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic high_event_irq_enable_r;
  logic low_event_irq_enable_r;
  logic latch_cfg_r;
  logic differential_irq_enable_r;
  logic self_reference_output_mode_r;
  logic self_reference_irq_mode_r;
  logic zero_active_r;
  logic [7:0] ths_low_r;
  logic [7:0] ths_high_r;
  logic [PW-1:0] reference_r;
  logic [PW-1:0] reference_nxt;
  logic [7:0] cfg_view;
  logic [7:0] rdata_nxt;
  logic out_mode_nxt;
  logic irq_mode_nxt;
  logic [PW-1:0] press_out_nxt;
  logic irq_high_nxt;
  logic irq_low_nxt;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  logic wr_cfg;
  logic wr_ths_low;
  logic wr_ths_high;
  logic rst_out_req;
  logic rst_irq_req;

  assign wr_cfg = reg_wr_i && (reg_addr_i == ptirq_pkg::IRQ_CFG_ADDR);
  assign wr_ths_low = reg_wr_i && (reg_addr_i == ptirq_pkg::THS_LOW_ADDR);
  assign wr_ths_high = reg_wr_i && (reg_addr_i == ptirq_pkg::THS_HIGH_ADDR);
  assign rst_out_req = wr_cfg && reg_wdata_i[ptirq_pkg::CFG_RESET_OUT_BIT];
  assign rst_irq_req = wr_cfg && reg_wdata_i[ptirq_pkg::CFG_RESET_IRQ_BIT];

  ////////////////////////////////////////////////////////////////////////
  // threshold and compare

  logic [14:0] pressure_threshold;
  logic [PW-1:0] differential_pressure;
  logic above;
  logic below;
  logic capture;
  logic function_active;

  assign pressure_threshold = {ths_high_r[6:0], ths_low_r};
  assign capture = conv_done_i && (self_reference_output_mode_r || self_reference_irq_mode_r);
  // reference taken this conversion is used at once, differential zero
  assign reference_nxt = capture ? measured_i : reference_r;
  assign function_active = differential_irq_enable_r
    && (high_event_irq_enable_r || low_event_irq_enable_r);

  ptirq_compare #(
    .PW(PW),
    .SHIFT(ptirq_pkg::PRESS_TO_THS_SHIFT)
  ) u_compare (
    .measured_i(measured_i),
    .reference_i(reference_nxt),
    .threshold_i(pressure_threshold),
    .differential_o(differential_pressure),
    .above_o(above),
    .below_o(below)
  );

  ////////////////////////////////////////////////////////////////////////
  // configuration register; a software set wins over the self-clear

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_event_irq_enable_r <= 1'b0;
      low_event_irq_enable_r <= 1'b0;
      latch_cfg_r <= 1'b0;
      differential_irq_enable_r <= 1'b0;
    end else if (wr_cfg) begin
      high_event_irq_enable_r <= reg_wdata_i[ptirq_pkg::CFG_HIGH_EN_BIT];
      low_event_irq_enable_r <= reg_wdata_i[ptirq_pkg::CFG_LOW_EN_BIT];
      latch_cfg_r <= reg_wdata_i[ptirq_pkg::CFG_LATCH_BIT];
      differential_irq_enable_r <= reg_wdata_i[ptirq_pkg::CFG_DIFFERENTIAL_IRQ_ENABLE_BIT];
    end
  end

  // self-reference mode bits clear after the capturing conversion;
  // a write in the same cycle wins so software can re-arm at once
  assign out_mode_nxt = wr_cfg ? reg_wdata_i[ptirq_pkg::CFG_OUT_MODE_BIT]
    : (self_reference_output_mode_r && !conv_done_i);
  assign irq_mode_nxt = wr_cfg ? reg_wdata_i[ptirq_pkg::CFG_IRQ_MODE_BIT]
    : (self_reference_irq_mode_r && !conv_done_i);

  // mode bit registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      self_reference_output_mode_r <= 1'b0;
      self_reference_irq_mode_r <= 1'b0;
    end else begin
      self_reference_output_mode_r <= out_mode_nxt;
      self_reference_irq_mode_r <= irq_mode_nxt;
    end
  end

  // threshold bytes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ths_low_r <= ptirq_pkg::THS_BYTE_RESET;
      ths_high_r <= ptirq_pkg::THS_BYTE_RESET;
    end else begin
      if (wr_ths_low) ths_low_r <= reg_wdata_i;
      if (wr_ths_high) ths_high_r <= reg_wdata_i & ptirq_pkg::THS_HIGH_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference and output-zeroing state; a capture wins over a reset

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reference_r <= ptirq_pkg::REF_RESET;
      zero_active_r <= 1'b0;
    end else if (capture) begin
      reference_r <= measured_i;
      zero_active_r <= zero_active_r || self_reference_output_mode_r;
    end else if (rst_out_req) begin
      reference_r <= ptirq_pkg::REF_RESET;
      zero_active_r <= 1'b0;
    end else if (rst_irq_req && !zero_active_r) begin
      reference_r <= ptirq_pkg::REF_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-conversion outputs and interrupt requests

  // zeroing mode reports the difference, else the raw value; the mode bit
  // counts too so the capturing conversion already reports zero
  assign press_out_nxt = (zero_active_r || self_reference_output_mode_r)
    ? differential_pressure : measured_i;
  // each direction gated by its own event enable
  assign irq_high_nxt = high_event_irq_enable_r && above;
  assign irq_low_nxt = low_event_irq_enable_r && below;

  // output registers, loaded on each conversion
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      press_out_o <= '0;
      differential_pressure_o <= '0;
      press_valid_o <= 1'b0;
    end else begin
      press_valid_o <= conv_done_i;
      if (conv_done_i) begin
        differential_pressure_o <= differential_pressure;
        press_out_o <= press_out_nxt;
      end
    end
  end

  // requests follow each conversion, drop at once when disabled
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_high_o <= 1'b0;
      irq_low_o <= 1'b0;
    end else if (!function_active) begin
      irq_high_o <= 1'b0;
      irq_low_o <= 1'b0;
    end else if (conv_done_i) begin
      irq_high_o <= irq_high_nxt;
      irq_low_o <= irq_low_nxt;
    end
  end

  assign irq_o = irq_high_o || irq_low_o;

  ////////////////////////////////////////////////////////////////////////
  // read port; reset strobes read as zero, unmapped reads zero

  assign cfg_view = {self_reference_irq_mode_r, 1'b0, self_reference_output_mode_r, 1'b0,
    differential_irq_enable_r, latch_cfg_r, low_event_irq_enable_r, high_event_irq_enable_r};
  assign rdata_nxt = (reg_addr_i == ptirq_pkg::IRQ_CFG_ADDR) ? cfg_view
    : (reg_addr_i == ptirq_pkg::THS_LOW_ADDR) ? ths_low_r
    : (reg_addr_i == ptirq_pkg::THS_HIGH_ADDR) ? ths_high_r
    : 8'h00;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

endmodule : ptirq_top

// >>> testbench/ptirq_checker.sv
// checker: port assertions for the pressure threshold interrupt block
// assumes a bind to ptirq_top, one clock, async active-low reset
`timescale 1ns/1ns
module ptirq_checker #(
  parameter int PW = 24
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic conv_done_i,
  input wire logic [PW-1:0] differential_pressure_o,
  input wire logic press_valid_o,
  input wire logic irq_high_o,
  input wire logic irq_low_o,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  // conversion taken, or a quiet cycle
  sequence conv_s; conv_done_i; endsequence
  sequence idle_s; !conv_done_i; endsequence
  // config write that clears the differential enable
  sequence cfg_off_s;
    reg_wr_i && (reg_addr_i == ptirq_pkg::IRQ_CFG_ADDR)
      && !reg_wdata_i[ptirq_pkg::CFG_DIFFERENTIAL_IRQ_ENABLE_BIT];
  endsequence
  // results follow each conversion by one cycle
  valid_pulse_a: assert property (conv_s |=> press_valid_o)
    else $error("valid pulse missing");
  spare_valid_a: assert property (idle_s |=> !press_valid_o)
    else $error("valid without conversion");
  diff_hold_a: assert property (idle_s |=> $stable(differential_pressure_o))
    else $error("differential moved between conversions");
  irq_cause_a: assert property ($rose(irq_o) |-> $past(conv_done_i))
    else $error("request rose without conversion");
  // request direction matches the sign of the difference
  high_sign_a: assert property (irq_high_o |->
    !differential_pressure_o[PW-1] && |differential_pressure_o) else $error("high sign");
  low_sign_a: assert property (irq_low_o |-> differential_pressure_o[PW-1])
    else $error("low sign");
  one_dir_a: assert property (!(irq_high_o && irq_low_o))
    else $error("both directions");
  irq_join_a: assert property (irq_o == (irq_high_o | irq_low_o))
    else $error("irq not joined");
  // disabling the function drops any request within two edges
  irq_off_a: assert property (cfg_off_s |-> ##2 !irq_o)
    else $error("request outlived disable");
  reset_quiet_a: assert property ($rose(rst_n_i) |-> !irq_o && !press_valid_o)
    else $error("busy after reset");
endmodule : ptirq_checker

// >>> testbench/tb_top.sv
// testbench: registers, self-reference modes and threshold requests
// assumes fixed one-cycle answers from ptirq_top, no waits needed
`timescale 1ns/1ns
module tb_top;
  logic clock_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, conv_done_i = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [23:0] measured_i = 24'h000000, press_out_o, differential_pressure_o;
  logic press_valid_o, irq_high_o, irq_low_o, irq_o;
  int n_mismatch = 0, comparisons = 0;
  ptirq_top ptirq_top_i (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .conv_done_i(conv_done_i),
    .measured_i(measured_i),
    .press_out_o(press_out_o),
    .differential_pressure_o(differential_pressure_o),
    .press_valid_o(press_valid_o),
    .irq_high_o(irq_high_o),
    .irq_low_o(irq_low_o),
    .irq_o(irq_o)
  );
  ////////////////////////////////////////
  // clock, 100 ns period
  initial forever #50 clock_i = ~clock_i;
  // shared compare, write, read and conversion; an idle edge after each write, read and conversion
  // so no strobe is lowered and raised again in one time step
  task automatic chk(input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
    @(negedge clock_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    chk({16'h0000, e}, {16'h0000, reg_rdata_o});
    @(negedge clock_i);
  endtask : rd
  task automatic cv(input int m, input int o, input int d, input logic h, input logic l);
    measured_i = m[23:0];
    conv_done_i = 1'b1;
    @(negedge clock_i);
    conv_done_i = 1'b0;
    chk(24'h000001, {23'h000000, press_valid_o});
    chk(o[23:0], press_out_o);
    chk(d[23:0], differential_pressure_o);
    chk({21'h000000, h, l, h | l}, {21'h000000, irq_high_o, irq_low_o, irq_o});
    @(negedge clock_i);
    chk(24'h000000, {23'h000000, press_valid_o});
  endtask : cv
  ////////////////////////////////////////
  // reset values, unmapped place, unused threshold bit, strobes read zero
  task automatic t_regs;
    rd(8'h0b, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h0e, 8'h00);
    wr(8'h0d, 8'hff);
    rd(8'h0d, 8'h7f);
    wr(8'h0b, 8'h54);
    rd(8'h0b, 8'h04);
    $display("regs done");
  endtask : t_regs
  // irq reference mode, threshold 1 count = 256, both boundaries
  task automatic t_refirq;
    wr(8'h0d, 8'h00);
    wr(8'h0c, 8'h01);
    wr(8'h0b, 8'h8b);
    cv(1000, 1000, 0, 0, 0);
    rd(8'h0b, 8'h0b);
    cv(1257, 1257, 257, 1, 0);
    cv(1256, 1256, 256, 0, 0);
    cv(743, 743, -257, 0, 1);
    cv(744, 744, -256, 0, 0);
    $display("refirq done");
  endtask : t_refirq
  // gating by the enables
  task automatic t_gate;
    wr(8'h0b, 8'h03);
    cv(1257, 1257, 257, 0, 0);
    wr(8'h0b, 8'h08);
    cv(743, 743, -257, 0, 0);
    wr(8'h0b, 8'h09);
    cv(743, 743, -257, 0, 0);
    cv(1257, 1257, 257, 1, 0);
    wr(8'h0b, 8'h0a);
    cv(1257, 1257, 257, 0, 0);
    $display("gate done");
  endtask : t_gate
  // output zeroing mode, capture then difference
  task automatic t_zero;
    wr(8'h0b, 8'h29);
    cv(2000, 0, 0, 0, 0);
    cv(2300, 300, 300, 1, 0);
    $display("zero done");
  endtask : t_zero
  // reset strobes end zeroing and drop the reference; disable drops a request
  task automatic t_clear;
    wr(8'h0b, 8'h19);
    rd(8'h0b, 8'h09);
    cv(2300, 2300, 2300, 1, 0);
    wr(8'h0b, 8'h89);
    cv(500, 500, 0, 0, 0);
    wr(8'h0b, 8'h49);
    cv(500, 500, 500, 1, 0);
    wr(8'h0b, 8'h01);
    chk(24'h000000, {23'h000000, irq_o});
    $display("clear done");
  endtask : t_clear
  task automatic complete_run;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (4) @(negedge clock_i);
    rst_n_i = 1;
    @(negedge clock_i);
    t_regs();
    t_refirq();
    t_gate();
    t_zero();
    t_clear();
    complete_run();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clock_i);
    n_mismatch++;
    complete_run();
  end
endmodule : tb_top
bind ptirq_top ptirq_checker #(.PW(PW)) ptirq_checker_i (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .conv_done_i(conv_done_i), .press_valid_o(press_valid_o),
  .differential_pressure_o(differential_pressure_o), .irq_high_o(irq_high_o),
  .irq_low_o(irq_low_o), .irq_o(irq_o));
